// ===== logic/pbl_bias_loop_regs.sv
// gate-bias loop stepping, lock and register bank
`timescale 1ns/1ps
// Summary of operation
// - steps only with loop enable, data high, clocks
// - gate-bias wiper has 256 taps
// - direction change with loop enabled freezes wiper and locks
// - loop enable low holds wiper still
// - status register sits at 0x0F
// - status bit 7 mirrors power-off pin
// - status bit 6 mirrors step direction
// - status bit 4 mirrors loop enable
// - write unlock is volatile, clear at power-up
// - unlock clear means writes are volatile only
// - unlock set by 0x02, effective after stop
// - unlock cleared by 0x00 or power-up
// - bit 0 selects gains, default zero
// - 0x00 gate-bias byte, 0x01 six-bit reference
// - each serial clock fall steps one tap
// - wiper saturates at both ends
// - power-up recalls stored wiper, factory zero
module pbl_bias_loop_regs (
  // clock and reset (reset stands for power-up recall)
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // pins, asynchronous
  input wire logic serial_clk_i,
  input wire logic serial_data_i,
  input wire logic loop_enable_i,
  input wire logic power_off_request_i,
  input wire logic step_direction_i,
  // decoded register access from the serial framing logic
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic stop_i,
  // register read data
  output logic [7:0] reg_rdata_o,
  // nonvolatile store request and analog settings
  output logic nv_store_o,
  output logic [7:0] gate_bias_tap_o,
  output logic [5:0] reference_tap_o,
  output logic gain_select_bit_o,
  output logic locked_o
);
  logic [4:0] pins_s;
  logic sclk_s, sdata_s, loop_s, poff_s, dir_s;
  logic sclk_d_r, dir_d_r;
  // after power-up the saved settings are copied back in one cycle
  typedef enum logic {PH_RECALL, PH_RUN} pbl_phase_t;
  logic [7:0] wiper_position_register_r, wiper_nxt;
  logic [7:0] nv_gate_bias_r;
  logic [5:0] reference_r, nv_reference_r;
  logic nv_write_unlock_r, unlock_pend_r, unlock_val_r;
  logic gain_r, nv_gain_r, locked_r;
  logic [5:0] reference_nxt;
  logic gain_nxt;
  logic [7:0] base_tap;
  logic [7:0] status_word;
  pbl_phase_t phase_r, phase_nxt;

  // the ports are fixed widths, so refuse package values they cannot carry
  if (pbl_pkg::TAP_W != 8 || pbl_pkg::DATA_W != 8 || pbl_pkg::ADDR_W != 8) begin : g_width_chk
    $error("pbl_bias_loop_regs serves only 8-bit taps, data and addresses");
  end
  if (pbl_pkg::REF_W != 6) begin : g_ref_chk
    $error("pbl_bias_loop_regs serves only a 6-bit reference");
  end
  if (pbl_pkg::ADDR_STATUS == pbl_pkg::ADDR_GATE_BIAS ||
      pbl_pkg::ADDR_STATUS == pbl_pkg::ADDR_REFERENCE) begin : g_addr_chk
    $error("status address must stay apart from the control bytes");
  end

  // address match, shared by the write strobes and the read select
  function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] want);
    return addr == want;
  endfunction

  // one saturating tap step; a wrap would swing the gate bias end to end
  function automatic logic [7:0] step_tap(input logic [7:0] tap, input logic up);
    logic [7:0] result;
    result = tap;
    if (up && tap != pbl_pkg::TAP_MAX) begin
      result = tap + 8'h01;
    end else if (!up && tap != pbl_pkg::TAP_MIN) begin
      result = tap - 8'h01;
    end
    return result;
  endfunction

  pbl_sync #(.WIDTH(5)) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .async_i({serial_clk_i, serial_data_i, loop_enable_i, power_off_request_i,
              step_direction_i}),
    .sync_o(pins_s)
  );
  assign {sclk_s, sdata_s, loop_s, poff_s, dir_s} = pins_s;

  wire sclk_fall = sclk_d_r & ~sclk_s;
  wire dir_edge = dir_d_r ^ dir_s;
  wire loop_step = loop_s & sdata_s & sclk_fall & ~locked_r;
  wire hit_gate = addr_is(reg_addr_i, pbl_pkg::ADDR_GATE_BIAS);
  wire hit_ref = addr_is(reg_addr_i, pbl_pkg::ADDR_REFERENCE);
  wire hit_stat = addr_is(reg_addr_i, pbl_pkg::ADDR_STATUS);
  wire wr_gate = reg_wr_i & hit_gate;
  wire wr_ref = reg_wr_i & hit_ref;
  wire wr_stat = reg_wr_i & hit_stat;
  wire stat_unlock_cmd = wr_stat & ((reg_wdata_i == pbl_pkg::SR_UNLOCK_SET) |
                                    (reg_wdata_i == pbl_pkg::SR_UNLOCK_CLR));
  wire nv_ok = nv_write_unlock_r;

  // next values: a write beats a step and the power-up recall; no step is taken during the recall
  always_comb begin
    phase_nxt = PH_RUN;
    base_tap = wiper_position_register_r;
    reference_nxt = reference_r;
    gain_nxt = gain_r;
    case (phase_r)
      PH_RECALL: begin
        base_tap = nv_gate_bias_r;
        reference_nxt = nv_reference_r;
        gain_nxt = nv_gain_r;
      end
      PH_RUN: begin
        phase_nxt = PH_RUN;
      end
      default: begin
        phase_nxt = PH_RUN;
      end
    endcase
    wiper_nxt = base_tap;
    if (wr_gate) begin
      wiper_nxt = reg_wdata_i;
    end else if (loop_step && phase_r == PH_RUN) begin
      wiper_nxt = step_tap(wiper_position_register_r, dir_s);
    end
    if (wr_ref) begin
      reference_nxt = reg_wdata_i[5:0];
    end
    if (wr_stat && !stat_unlock_cmd) begin
      gain_nxt = reg_wdata_i[pbl_pkg::SR_GAIN];
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_d_r <= 1'b0;
      dir_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
      dir_d_r <= dir_s;
    end
  end

  // reset models power-up; the saved values are recalled on the next cycle
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r <= PH_RECALL;
      wiper_position_register_r <= pbl_pkg::FACTORY_TAP;
      reference_r <= pbl_pkg::FACTORY_REF;
      gain_r <= pbl_pkg::FACTORY_GAIN;
    end else begin
      phase_r <= phase_nxt;
      wiper_position_register_r <= wiper_nxt;
      reference_r <= reference_nxt;
      gain_r <= gain_nxt;
    end
  end

  // lock: a direction edge while the loop runs freezes the wiper until loop re-enables
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      locked_r <= 1'b0;
    end else if (loop_s && dir_edge) begin
      locked_r <= 1'b1;
    end else if (!loop_s) begin
      locked_r <= 1'b0;
    end
  end

  // nonvolatile shadow copies, only touched when unlocked
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nv_gate_bias_r <= pbl_pkg::FACTORY_TAP;
      nv_reference_r <= pbl_pkg::FACTORY_REF;
      nv_gain_r <= pbl_pkg::FACTORY_GAIN;
      nv_store_o <= 1'b0;
    end else begin
      nv_store_o <= nv_ok & (wr_gate | wr_ref | (wr_stat & ~stat_unlock_cmd));
      if (nv_ok && wr_gate) begin
        nv_gate_bias_r <= reg_wdata_i;
      end
      if (nv_ok && wr_ref) begin
        nv_reference_r <= reg_wdata_i[5:0];
      end
      if (nv_ok && wr_stat && !stat_unlock_cmd) begin
        nv_gain_r <= reg_wdata_i[pbl_pkg::SR_GAIN];
      end
    end
  end

  // unlock takes effect only at the stop that ends its write
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      nv_write_unlock_r <= 1'b0;
      unlock_pend_r <= 1'b0;
      unlock_val_r <= 1'b0;
    end else begin
      if (stat_unlock_cmd) begin
        unlock_pend_r <= 1'b1;
        unlock_val_r <= reg_wdata_i[pbl_pkg::SR_UNLOCK];
      end else if (stop_i && unlock_pend_r) begin
        unlock_pend_r <= 1'b0;
        nv_write_unlock_r <= unlock_val_r;
      end
    end
  end

  // status bits placed by position; test bits 5, 3 and 2 stay zero
  always_comb begin
    status_word = 8'h00;
    status_word[pbl_pkg::SR_POWER_OFF] = poff_s;
    status_word[pbl_pkg::SR_DIRECTION] = dir_s;
    status_word[pbl_pkg::SR_LOOP_EN] = loop_s;
    status_word[pbl_pkg::SR_UNLOCK] = nv_write_unlock_r;
    status_word[pbl_pkg::SR_GAIN] = gain_r;
  end

  wire [7:0] rd_mux = hit_gate ? wiper_position_register_r :
                      hit_ref ? {2'b00, reference_r} :
                      hit_stat ? status_word : 8'h00;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  assign gate_bias_tap_o = wiper_position_register_r;
  assign reference_tap_o = reference_r;
  assign gain_select_bit_o = gain_r;
  assign locked_o = locked_r;
endmodule

// ===== logic/pbl_pkg.sv
// constants for the bias loop control register bank
package pbl_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned TAP_W = 8;
  localparam int unsigned REF_W = 6;
  localparam logic [7:0] TAP_MAX = 8'hFF;
  localparam logic [7:0] TAP_MIN = 8'h00;
  localparam logic [7:0] ADDR_GATE_BIAS = 8'h00;
  localparam logic [7:0] ADDR_REFERENCE = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h0F;
  localparam int unsigned SR_POWER_OFF = 7;
  localparam int unsigned SR_DIRECTION = 6;
  localparam int unsigned SR_LOOP_EN = 4;
  localparam int unsigned SR_UNLOCK = 1;
  localparam int unsigned SR_GAIN = 0;
  localparam logic [7:0] SR_UNLOCK_SET = 8'h02;
  localparam logic [7:0] SR_UNLOCK_CLR = 8'h00;
  localparam logic [7:0] FACTORY_TAP = 8'h00;
  localparam logic [5:0] FACTORY_REF = 6'h00;
  localparam logic FACTORY_GAIN = 1'b0;
endpackage

// ===== logic/pbl_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
module pbl_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // level in and out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;
  if (WIDTH < 1) begin : g_width_chk
    $error("pbl_sync needs WIDTH >= 1");
  end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule

// ===== test/pbl_bias_loop_regs_properties.sv
// port assertions for the bias loop register bank
`timescale 1ns/1ps
module pbl_bias_loop_regs_properties (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic loop_enable_i,
  input wire logic power_off_request_i,
  input wire logic step_direction_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic nv_store_o,
  input wire logic [7:0] gate_bias_tap_o,
  input wire logic gain_select_bit_o,
  input wire logic locked_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire rd_st = reg_rd_i && reg_addr_i == 8'h0F;
  nv_cause_a: assert property (nv_store_o |-> $past(reg_wr_i))
    else $error("nv store without write");
  gate_write_a: assert property (reg_wr_i && reg_addr_i == 8'h00 |=>
    gate_bias_tap_o == $past(reg_wdata_i)) else $error("wiper write lost");
  test_bits_a: assert property (rd_st |=> (reg_rdata_o & 8'h2C) == 8'h00)
    else $error("test bits not zero");
  poff_copy_a: assert property ($stable(power_off_request_i)[*4] ##0 rd_st |=>
    reg_rdata_o[7] == $past(power_off_request_i)) else $error("power off bit");
  dir_copy_a: assert property ($stable(step_direction_i)[*4] ##0 rd_st |=>
    reg_rdata_o[6] == $past(step_direction_i)) else $error("direction bit");
  no_wrap_a: assert property (!reg_wr_i && (gate_bias_tap_o inside {8'hFF, 8'h00}) |=>
    gate_bias_tap_o != ~$past(gate_bias_tap_o)) else $error("wiper wrapped");
  open_hold_a: assert property (!loop_enable_i[*6] ##0 !reg_wr_i |=>
    $stable(gate_bias_tap_o)) else $error("wiper moved in open loop");
  gain_write_a: assert property (reg_wr_i && reg_addr_i == 8'h0F &&
    !(reg_wdata_i inside {8'h00, 8'h02}) |=> gain_select_bit_o == $past(reg_wdata_i[0]))
    else $error("gain bit not written");
  lock_hold_a: assert property (locked_o && !reg_wr_i |=> $stable(gate_bias_tap_o))
    else $error("wiper moved while locked");
  cover property (nv_store_o);
  cover property (locked_o);
  cover property (gate_bias_tap_o == 8'hFF);
endmodule
bind pbl_bias_loop_regs pbl_bias_loop_regs_properties pbl_bias_loop_regs_properties_i (.*);

// ===== test/pbl_host_pins.sv
// host side model: serial clock bursts with data held high
`timescale 1ns/1ps
module pbl_host_pins (
  input wire logic sys_clk_i,
  output logic serial_clk_o,
  output logic serial_data_o
);
  // clock idles high like a pulled-up line, only bursts when asked
  initial begin
    serial_clk_o = 1'b1;
    serial_data_o = 1'b1;
  end
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk_i);
      #1 serial_clk_o = 1'b0;
      repeat (4) @(posedge sys_clk_i);
      #1 serial_clk_o = 1'b1;
    end
    repeat (8) @(posedge sys_clk_i);
  endtask
endmodule

// ===== test/pa_bias_loop_control_regs_test.sv
// self-checking bench for the bias loop register bank
`timescale 1ns/1ps
module pa_bias_loop_control_regs_test;
  logic sys_clk_i = 0, rst_i = 1, wr = 0, rd = 0, stp = 0, pof = 0, dir = 0, lp = 0;
  logic sck, sda, gn, lk, nvs, nv;
  logic [7:0] adr = 0, wd = 0, rdat, gb;
  logic [5:0] rf;
  int failures = 0, cmp_count = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  pbl_host_pins pbl_host_pins_i (.sys_clk_i, .serial_clk_o(sck), .serial_data_o(sda));
  pbl_bias_loop_regs pbl_bias_loop_regs_i (.sys_clk_i, .rst_i, .serial_clk_i(sck),
    .serial_data_i(sda), .loop_enable_i(lp), .power_off_request_i(pof),
    .step_direction_i(dir), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(adr),
    .reg_wdata_i(wd), .stop_i(stp), .reg_rdata_o(rdat), .nv_store_o(nvs),
    .gate_bias_tap_o(gb), .reference_tap_o(rf), .gain_select_bit_o(gn), .locked_o(lk));
  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrt(input logic [7:0] a, d);
    @(posedge sys_clk_i) #1 {wr, adr, wd} = {1'b1, a, d};
    @(posedge sys_clk_i) #1 {wr, nv} = {1'b0, nvs};
    @(posedge sys_clk_i) #1 nv = nv | nvs;
  endtask
  task automatic rdc(input logic [7:0] a, exp);
    @(posedge sys_clk_i) #1 {rd, adr} = {1'b1, a};
    @(posedge sys_clk_i) #1 rd = 0;
    @(posedge sys_clk_i) #1 chk(rdat, exp);
  endtask
  task automatic stop;
    @(posedge sys_clk_i) #1 stp = 1;
    @(posedge sys_clk_i) #1 stp = 0;
  endtask
  // pins pass a two-flop synchroniser, so let them settle before use
  task automatic pins(input logic p, d, l);
    @(posedge sys_clk_i) #1 {pof, dir, lp} = {p, d, l};
    repeat (6) @(posedge sys_clk_i);
  endtask
  task automatic test_done;
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    failures++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge sys_clk_i);
    #1 rst_i = 0;
    rdc(8'h00, 8'h00);
    rdc(8'h0F, 8'h00);
    $display("reset test done");
    wrt(8'h00, 8'h55);
    chk({7'h00, nv}, 8'h00);
    rdc(8'h00, 8'h55);
    wrt(8'h01, 8'hFF);
    chk({2'h0, rf}, 8'h3F);
    wrt(8'h10, 8'hAA);
    rdc(8'h10, 8'h00);
    pins(1, 1, 1);
    rdc(8'h0F, 8'hD0);
    $display("register test done");
    wrt(8'h0F, 8'h02);
    stop;
    rdc(8'h0F, 8'hD2);
    wrt(8'h00, 8'hAA);
    chk({7'h00, nv}, 8'h01);
    wrt(8'h0F, 8'h00);
    stop;
    wrt(8'h00, 8'h11);
    chk({7'h00, nv}, 8'h00);
    wrt(8'h0F, 8'h01);
    rdc(8'h0F, 8'hD1);
    chk({7'h00, gn}, 8'h01);
    $display("unlock test done");
    pins(0, 1, 0);
    wrt(8'h00, 8'hFD);
    pins(0, 1, 1);
    pbl_host_pins_i.pulse(5);
    chk(gb, 8'hFF);
    pins(0, 0, 1);
    chk({7'h00, lk}, 8'h01);
    pbl_host_pins_i.pulse(2);
    chk(gb, 8'hFF);
    pins(0, 0, 0);
    pbl_host_pins_i.pulse(2);
    chk(gb, 8'hFF);
    pins(0, 0, 1);
    pbl_host_pins_i.pulse(3);
    chk(gb, 8'hFC);
    $display("stepping test done");
    test_done;
  end
endmodule
